// >>> hw/tsh_pkg.sv
// Constants and types for the touch-sensor SPI host controller.
// Assumes a 40 MHz system clock; every timing count below except SAMPLE_DLY_CYC is derived from it.
package tsh_pkg;

  localparam int CLK_PERIOD_NS = 25;
  localparam int CNT_W = 24;

  // Serial clock phases, select lead and hold, and the device reset pulse, in ns.
  localparam int SCK_HALF_NS = 666;
  localparam int ENABLE_DLY_NS = 1000;
  localparam int SS_HOLD_NS = 20;
  localparam int RST_LOW_NS = 1100;

  // Least times, rounded up to whole clock cycles.
  localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ENABLE_DLY_CYC = (ENABLE_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SS_HOLD_CYC = (SS_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_LOW_CYC = (RST_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Cycles from the rising serial clock edge to the shift of the synchronised input.
  localparam int SAMPLE_DLY_CYC = 3;

  // Gaps between exchanges, in microseconds.
  localparam int FULL_GAP_US = 300;
  localparam int QUICK_GAP_US = 100;
  localparam int FULL_GAP_CYC = (FULL_GAP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int QUICK_GAP_CYC = (QUICK_GAP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Recovery waits after long commands, in milliseconds.
  localparam int RESET_WAIT_MS = 320;
  localparam int STORE_WAIT_MS = 200;
  localparam int RESTORE_WAIT_MS = 150;
  localparam int ERASE_WAIT_MS = 50;
  localparam int RESET_WAIT_CYC = (RESET_WAIT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STORE_WAIT_CYC = (STORE_WAIT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESTORE_WAIT_CYC = (RESTORE_WAIT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_WAIT_CYC = (ERASE_WAIT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Request operations.
  localparam logic [1:0] OP_BYTE = 2'h0;
  localparam logic [1:0] OP_WAKE = 2'h1;
  localparam logic [1:0] OP_RESET = 2'h2;

  typedef enum logic [7:0] {
    S_IDLE  = 8'h01,
    S_RST   = 8'h02,
    S_WAKE  = 8'h04,
    S_LEAD  = 8'h08,
    S_LOW   = 8'h10,
    S_HIGH  = 8'h20,
    S_TRAIL = 8'h40,
    S_GAP   = 8'h80
  } tsh_state_t;

  // Wait class that follows an exchange; the first eight come from the user.
  typedef enum logic [3:0] {
    W_GEN     = 4'h0,
    W_SETUP   = 4'h1,
    W_CALIB   = 4'h2,
    W_STORE   = 4'h3,
    W_RESTORE = 4'h4,
    W_ERASE   = 4'h5,
    W_TO_FULL = 4'h6,
    W_WAKE    = 4'h7,
    W_RESET   = 4'h8
  } tsh_wait_t;

  typedef struct packed {
    tsh_state_t st;
    logic [CNT_W-1:0] cnt;
    logic [2:0] bits;
    logic [7:0] tx;
    logic [7:0] rx;
    tsh_wait_t cls;
    logic quick;
    logic sck;
    logic ss_n;
    logic mosi;
    logic rst_n;
    logic rsp_valid;
    logic [7:0] rsp;
    logic miso_s1;
    logic miso_s2;
    logic [7:0] ph_len;
    logic [CNT_W-1:0] since;
  } tsh_regs_t;

  localparam tsh_regs_t REGS_RST = '{
    st: S_IDLE, cnt: 24'h000000, bits: 3'h0, tx: 8'h00, rx: 8'h00, cls: W_GEN, quick: 1'b0,
    sck: 1'b1, ss_n: 1'b1, mosi: 1'b0, rst_n: 1'b1, rsp_valid: 1'b0, rsp: 8'h00,
    miso_s1: 1'b0, miso_s2: 1'b0, ph_len: 8'hff, since: 24'hffffff
  };

endpackage

// >>> hw/tsh_host.sv
// Host-side controller for a capacitive touch sensor reached over a four-wire serial link.
// Assumes the sensor is a link slave, its data output passes through two flip-flops here,
// and the user offers one request at a time through a valid/ready handshake.

// Overview of operation
// - Serial clock idles high; data changes on falling edge, sampled on rising edge.
// - Serial clock never runs faster than 750 kHz.
// - Each serial clock low and high phase lasts at least 666 ns.
// - Select goes low at least 1 us before the first falling clock edge.
// - Full mode: at least 300 us between successive byte exchanges.
// - Full mode: at least 300 us between transfers unless a longer wait applies.
// - After the last configuration byte returns, wait 300 us; in quick mode the code waits only the 100 us quick gap.
// - After a calibration command, wait at least 300 us; in quick mode the code waits only the 100 us quick gap.
// - Sleeping sensor wakes on select low; host then waits 300 us.
// - Full mode waits: reset 320 ms, store 200 ms, restore 150 ms, erase 50 ms.
// - Quick mode: at least 100 us between bytes and between transfers.
// - Quick mode waits: 200 ms after store, 300 us after return to full.
// - Device reset line is held low at least 1100 ns.
module tsh_host #(
  parameter logic [23:0] FULL_GAP_CYC = 24'(tsh_pkg::FULL_GAP_CYC),
  parameter logic [23:0] RESET_WAIT_CYC = 24'(tsh_pkg::RESET_WAIT_CYC),
  parameter logic [23:0] STORE_WAIT_CYC = 24'(tsh_pkg::STORE_WAIT_CYC),
  parameter logic [23:0] RESTORE_WAIT_CYC = 24'(tsh_pkg::RESTORE_WAIT_CYC),
  parameter logic [23:0] ERASE_WAIT_CYC = 24'(tsh_pkg::ERASE_WAIT_CYC)
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire logic [1:0] REQ_OP,
  input wire logic [7:0] REQ_BYTE,
  input wire logic [2:0] REQ_WAIT,
  input wire logic QUICK_MODE,
  output logic RSP_VALID,
  output logic [7:0] RSP_BYTE,
  output logic SPI_SCK,
  output logic SPI_SS_N,
  output logic SPI_MOSI,
  input wire logic SPI_MISO,
  output logic DEV_RST_N
);

  localparam logic [23:0] HALF_LD = 24'(tsh_pkg::SCK_HALF_CYC - 1);
  localparam logic [23:0] LEAD_LD = 24'(tsh_pkg::ENABLE_DLY_CYC - 1);
  localparam logic [23:0] HOLD_LD = 24'(tsh_pkg::SS_HOLD_CYC - 1);
  localparam logic [23:0] RST_LD = 24'(tsh_pkg::RST_LOW_CYC - 1);
  // Sampling a few cycles into the high phase allows for the two-flop input delay.
  localparam logic [23:0] SAMPLE_AT = 24'(tsh_pkg::SCK_HALF_CYC - tsh_pkg::SAMPLE_DLY_CYC);
  localparam logic [23:0] QUICK_LEN = 24'(tsh_pkg::QUICK_GAP_CYC);
  localparam logic [23:0] CNT_MAX = 24'hffffff;

  tsh_pkg::tsh_regs_t r_reg;
  tsh_pkg::tsh_regs_t r_next;
  logic start_go;

  // Length of the quiet time that must follow an exchange of the given class.
  function automatic logic [23:0] wait_len(input tsh_pkg::tsh_wait_t cls, input logic quick);
    logic [23:0] len;
    len = quick ? QUICK_LEN : FULL_GAP_CYC;
    case (cls)
      // Store waits are taken as given; real store times far exceed the base gap.
      // store recovery wait.
      tsh_pkg::W_STORE: len = STORE_WAIT_CYC;
      tsh_pkg::W_RESTORE: begin
        if (!quick) begin
          len = RESTORE_WAIT_CYC;
        end
      end
      tsh_pkg::W_ERASE: begin
        if (!quick) begin
          len = ERASE_WAIT_CYC;
        end
      end
      tsh_pkg::W_TO_FULL: len = FULL_GAP_CYC;
      tsh_pkg::W_WAKE: len = FULL_GAP_CYC;
      tsh_pkg::W_RESET: len = RESET_WAIT_CYC;
      default: len = quick ? QUICK_LEN : FULL_GAP_CYC;
    endcase
    return len;
  endfunction

  always_comb begin
    r_next = r_reg;
    r_next.rsp_valid = 1'b0;
    // The first stage feeds only the second one.
    r_next.miso_s1 = SPI_MISO;
    r_next.miso_s2 = r_reg.miso_s1;
    if (r_reg.cnt != 24'h000000) begin
      r_next.cnt = r_reg.cnt - 24'h000001;
    end
    unique case (r_reg.st)
      tsh_pkg::S_IDLE: begin
        if (REQ_VALID) begin
          r_next.quick = QUICK_MODE;
          if (REQ_OP == tsh_pkg::OP_RESET) begin
            r_next.st = tsh_pkg::S_RST;
            r_next.rst_n = 1'b0;
            r_next.cls = tsh_pkg::W_RESET;
            r_next.cnt = RST_LD;
          end else if (REQ_OP == tsh_pkg::OP_WAKE) begin
            r_next.st = tsh_pkg::S_WAKE;
            r_next.ss_n = 1'b0;
            r_next.cls = tsh_pkg::W_WAKE;
            r_next.cnt = LEAD_LD;
          end else begin
            r_next.st = tsh_pkg::S_LEAD;
            r_next.ss_n = 1'b0;
            r_next.cls = tsh_pkg::tsh_wait_t'({1'b0, REQ_WAIT});
            r_next.tx = REQ_BYTE;
            r_next.bits = 3'h7;
            r_next.cnt = LEAD_LD;
          end
        end
      end
      tsh_pkg::S_RST: begin
        if (r_reg.cnt == 24'h000000) begin
          r_next.rst_n = 1'b1;
          r_next.st = tsh_pkg::S_GAP;
          r_next.cnt = wait_len(r_reg.cls, r_reg.quick) - 24'h000001;
        end
      end
      tsh_pkg::S_WAKE: begin
        if (r_reg.cnt == 24'h000000) begin
          r_next.ss_n = 1'b1;
          r_next.st = tsh_pkg::S_GAP;
          r_next.cnt = wait_len(r_reg.cls, r_reg.quick) - 24'h000001;
        end
      end
      tsh_pkg::S_LEAD: begin
        if (r_reg.cnt == 24'h000000) begin
          r_next.st = tsh_pkg::S_LOW;
          r_next.sck = 1'b0;
          r_next.mosi = r_reg.tx[7];
          r_next.cnt = HALF_LD;
        end
      end
      tsh_pkg::S_LOW: begin
        if (r_reg.cnt == 24'h000000) begin
          r_next.st = tsh_pkg::S_HIGH;
          r_next.sck = 1'b1;
          r_next.cnt = HALF_LD;
        end
      end
      tsh_pkg::S_HIGH: begin
        if (r_reg.cnt == SAMPLE_AT) begin
          r_next.rx = {r_reg.rx[6:0], r_reg.miso_s2};
        end
        if (r_reg.cnt == 24'h000000) begin
          if (r_reg.bits == 3'h0) begin
            r_next.st = tsh_pkg::S_TRAIL;
            r_next.cnt = HOLD_LD;
          end else begin
            r_next.bits = r_reg.bits - 3'h1;
            r_next.tx = {r_reg.tx[6:0], 1'b0};
            r_next.mosi = r_reg.tx[6];
            r_next.sck = 1'b0;
            r_next.st = tsh_pkg::S_LOW;
            r_next.cnt = HALF_LD;
          end
        end
      end
      tsh_pkg::S_TRAIL: begin
        if (r_reg.cnt == 24'h000000) begin
          r_next.ss_n = 1'b1;
          r_next.rsp_valid = 1'b1;
          r_next.rsp = r_reg.rx;
          r_next.st = tsh_pkg::S_GAP;
          r_next.cnt = wait_len(r_reg.cls, r_reg.quick) - 24'h000001;
        end
      end
      tsh_pkg::S_GAP: begin
        if (r_reg.cnt == 24'h000000) begin
          r_next.st = tsh_pkg::S_IDLE;
        end
      end
      default: begin
        r_next = tsh_pkg::REGS_RST;
      end
    endcase
    // Phase and quiet-time counters, read only by the checks below.
    if (r_next.sck != r_reg.sck) begin
      r_next.ph_len = 8'h00;
    end else if (r_reg.ph_len != 8'hff) begin
      r_next.ph_len = r_reg.ph_len + 8'h01;
    end
    if (r_next.st == tsh_pkg::S_GAP && r_reg.st != tsh_pkg::S_GAP) begin
      r_next.since = 24'h000000;
    end else if (r_reg.since != CNT_MAX) begin
      r_next.since = r_reg.since + 24'h000001;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      r_reg <= tsh_pkg::REGS_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // The ready term is combinational so a request can be taken in the first idle cycle.
  assign REQ_READY = (r_reg.st == tsh_pkg::S_IDLE);
  assign RSP_VALID = r_reg.rsp_valid;
  assign RSP_BYTE = r_reg.rsp;
  assign SPI_SCK = r_reg.sck;
  assign SPI_SS_N = r_reg.ss_n;
  assign SPI_MOSI = r_reg.mosi;
  assign DEV_RST_N = r_reg.rst_n;
  assign start_go = (r_reg.st == tsh_pkg::S_IDLE) && REQ_VALID;

  localparam int HALF_M1 = tsh_pkg::SCK_HALF_CYC - 1;
  localparam int LEAD_M1 = tsh_pkg::ENABLE_DLY_CYC - 1;
  localparam int RST_M1 = tsh_pkg::RST_LOW_CYC - 1;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SRST);

  chk_idle_levels: assert property (
    r_reg.st == tsh_pkg::S_IDLE |-> SPI_SCK && SPI_SS_N && DEV_RST_N)
    else $error("Link lines not idle while controller idle.");

  chk_mosi_edge: assert property (
    $changed(SPI_MOSI) |-> $fell(SPI_SCK))
    else $error("Data out changed away from a falling clock edge.");

  chk_low_phase: assert property (
    $rose(SPI_SCK) |-> $past(r_reg.ph_len) == HALF_M1)
    else $error("Serial clock low phase has wrong length.");

  chk_high_phase: assert property (
    $fell(SPI_SCK) |-> $past(r_reg.ph_len) >= HALF_M1)
    else $error("Serial clock high phase too short.");

  chk_enable_lead: assert property (
    $fell(SPI_SS_N) && r_reg.st == tsh_pkg::S_LEAD |-> ##LEAD_M1 SPI_SCK ##1 !SPI_SCK)
    else $error("Select lead before first clock edge is wrong.");

  chk_byte_gap: assert property (
    start_go && !r_reg.quick && r_reg.cls == tsh_pkg::W_GEN |-> r_reg.since >= FULL_GAP_CYC)
    else $error("Full mode byte gap too short.");

  chk_full_gap: assert property (
    start_go && !r_reg.quick |-> r_reg.since >= FULL_GAP_CYC)
    else $error("Full mode gap between transfers too short.");

  chk_setup_wait: assert property (
    start_go && r_reg.cls == tsh_pkg::W_SETUP && !r_reg.quick |-> r_reg.since >= FULL_GAP_CYC)
    else $error("Wait after configuration read too short.");

  chk_calib_wait: assert property (
    start_go && r_reg.cls == tsh_pkg::W_CALIB && !r_reg.quick |-> r_reg.since >= FULL_GAP_CYC)
    else $error("Wait after calibration too short.");

  chk_wake_wait: assert property (
    start_go && r_reg.cls == tsh_pkg::W_WAKE |-> r_reg.since >= FULL_GAP_CYC)
    else $error("Wait after wake too short.");

  chk_long_wait: assert property (
    start_go && (r_reg.cls == tsh_pkg::W_RESET || (!r_reg.quick && (r_reg.cls == tsh_pkg::W_STORE
      || r_reg.cls == tsh_pkg::W_RESTORE || r_reg.cls == tsh_pkg::W_ERASE)))
      |-> r_reg.since >= wait_len(r_reg.cls, 1'b0))
    else $error("Recovery wait after long command too short.");

  // Store and switch-to-full carry their own waits, so the base quick gap does not bind them.
  chk_quick_gap: assert property (
    start_go && r_reg.quick && r_reg.cls != tsh_pkg::W_STORE && r_reg.cls != tsh_pkg::W_TO_FULL
      |-> r_reg.since >= QUICK_LEN)
    else $error("Quick mode gap too short.");

  chk_quick_store: assert property (
    start_go && r_reg.quick && r_reg.cls == tsh_pkg::W_STORE |-> r_reg.since >= STORE_WAIT_CYC)
    else $error("Quick mode store wait too short.");

  chk_reset_pulse: assert property (
    $fell(DEV_RST_N) |-> ##RST_M1 !DEV_RST_N ##1 DEV_RST_N)
    else $error("Device reset pulse has wrong length.");

  chk_frame_select: assert property (
    $rose(SPI_SS_N) && r_reg.st == tsh_pkg::S_GAP && $past(r_reg.st) == tsh_pkg::S_TRAIL
      |-> RSP_VALID && $past(r_reg.bits) == 3'h0)
    else $error("Select released before eight bits were exchanged.");

  // Frame-shape checks tie the select, clock, reset and response outputs together; chk_to_full_wait checks the return-to-full wait.
  chk_wake_pulse: assert property (
    $fell(SPI_SS_N) && r_reg.st == tsh_pkg::S_WAKE |-> ##LEAD_M1 !SPI_SS_N ##1 SPI_SS_N)
    else $error("Wake select pulse has wrong length.");

  chk_to_full_wait: assert property (
    start_go && r_reg.cls == tsh_pkg::W_TO_FULL |-> r_reg.since >= FULL_GAP_CYC)
    else $error("Wait after return to full mode too short.");

  chk_rsp_pulse: assert property (
    RSP_VALID |=> !RSP_VALID)
    else $error("Response strobe longer than one cycle.");

  chk_rsp_hold: assert property (
    $changed(RSP_BYTE) |-> RSP_VALID)
    else $error("Response byte changed without a response strobe.");

  chk_sck_select: assert property (
    !SPI_SCK |-> !SPI_SS_N)
    else $error("Serial clock low while select is high.");

  chk_trail_hold: assert property (
    $rose(SPI_SS_N) |-> $past(SPI_SCK))
    else $error("Select released too soon after the last clock edge.");

  chk_frame_low: assert property (
    (r_reg.st == tsh_pkg::S_LOW || r_reg.st == tsh_pkg::S_HIGH) |-> !SPI_SS_N)
    else $error("Select high in the middle of an exchange.");

  chk_reset_quiet: assert property (
    !DEV_RST_N |-> SPI_SS_N && SPI_SCK)
    else $error("Link active during the device reset pulse.");

  chk_gap_quiet: assert property (
    r_reg.st == tsh_pkg::S_GAP |-> SPI_SS_N && SPI_SCK && DEV_RST_N)
    else $error("Link not quiet during the gap.");

  cov_byte_done: cover property (r_reg.st == tsh_pkg::S_TRAIL ##1 RSP_VALID);
  cov_reset_done: cover property ($rose(DEV_RST_N));
  cov_wake_done: cover property (r_reg.st == tsh_pkg::S_WAKE ##1 r_reg.st == tsh_pkg::S_GAP);
  cov_quick_start: cover property (start_go && QUICK_MODE && REQ_OP == tsh_pkg::OP_BYTE);
  cov_to_full: cover property (start_go && r_reg.quick && r_reg.cls == tsh_pkg::W_TO_FULL);

endmodule

// >>> bench/tsh_dev_model.sv
// Behavioural model of the touch sensor's serial slave port and reset pin.
// Assumes one host drives select, clock, data and reset; host timing slips are counted in viol.
module tsh_dev_model #(
  parameter int MIN_GAP_NS = 5000
) (
  input wire logic sck,
  input wire logic ss_n,
  input wire logic mosi,
  output logic miso,
  input wire logic rst_n,
  input wire logic [7:0] reply,
  output logic [7:0] got,
  output logic [7:0] viol
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int OSC_HZ = 8000000;
  realtime t_sel = 0.0;
  realtime t_fall = 0.0;
  realtime t_rise = 0.0;
  realtime t_desel = -1.0e9;
  realtime t_rst = 0.0;
  logic [7:0] sh = 8'h00;
  logic [7:0] rx = 8'h00;
  logic awake = 1'b0;
  int bits = 0;
  initial begin
    miso = 1'b0;
    got = 8'h00;
    viol = 8'h00;
  end
  always @(negedge ss_n) begin
    awake = 1'b1;
    if ($realtime - t_desel < MIN_GAP_NS) viol = viol + 8'h01;
    t_sel = $realtime;
    sh = reply;
    bits = 0;
  end
  always @(negedge sck) begin
    if (ss_n !== 1'b0 || $realtime - t_sel < 1000.0) viol = viol + 8'h01;
    if (bits > 0 && ($realtime - t_rise < 666.0 || $realtime - t_fall < 1332.0)) viol = viol + 8'h01;
    t_fall = $realtime;
    miso = sh[7];
  end
  always @(posedge sck) begin
    if ($realtime > 100.0 && (ss_n !== 1'b0 || $realtime - t_fall < 666.0)) viol = viol + 8'h01;
    rx = {rx[6:0], mosi};
    sh = {sh[6:0], 1'b0};
    bits = bits + 1;
    t_rise = $realtime;
  end
  always @(posedge ss_n) begin
    // The power-up edge out of X is no frame end, so it must not start a gap.
    if ($realtime > 100.0) begin
      if (bits != 0 && (bits != 8 || $realtime - t_rise < 20.0)) viol = viol + 8'h01;
      if (bits == 8) got = rx;
      miso = ~miso;
      t_desel = $realtime;
    end
  end
  always @(negedge rst_n) t_rst = $realtime;
  always @(posedge rst_n) if ($realtime > 100.0 && $realtime - t_rst < 1100.0) viol = viol + 8'h01;
endmodule

// >>> bench/tsh_host_tb.sv
// Self-checking bench for the touch sensor link host controller.
// Assumes the sensor model tsh_dev_model; long waits are shortened through parameters.
module tsh_host_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FULL_W = 200;
  localparam int RESET_W = 2000;
  localparam int STORE_W = 1500;
  localparam int RESTORE_W = 1000;
  localparam int ERASE_W = 500;
  localparam int BYTE_LEN = tsh_pkg::ENABLE_DLY_CYC + 16 * tsh_pkg::SCK_HALF_CYC + 1;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic req_valid = 1'b0;
  logic [1:0] req_op = 2'h0;
  logic [7:0] req_byte = 8'h00;
  logic [2:0] req_wait = 3'h0;
  logic quick = 1'b0;
  logic [7:0] reply = 8'h00;
  logic req_ready, rsp_valid, sck, ss_n, mosi, miso, rst_n;
  logic [7:0] rsp_byte, got, viol;
  int err_count = 0;
  int checks_done = 0;
  initial begin
    forever #12.5 clk = ~clk;
  end
  tsh_host #(.FULL_GAP_CYC(24'(FULL_W)), .RESET_WAIT_CYC(24'(RESET_W)), .STORE_WAIT_CYC(24'(STORE_W)),
    .RESTORE_WAIT_CYC(24'(RESTORE_W)), .ERASE_WAIT_CYC(24'(ERASE_W))) uut (.CLK(clk), .SRST(srst),
    .REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ_OP(req_op), .REQ_BYTE(req_byte), .REQ_WAIT(req_wait),
    .QUICK_MODE(quick), .RSP_VALID(rsp_valid), .RSP_BYTE(rsp_byte), .SPI_SCK(sck), .SPI_SS_N(ss_n),
    .SPI_MOSI(mosi), .SPI_MISO(miso), .DEV_RST_N(rst_n));
  tsh_dev_model #(.MIN_GAP_NS(FULL_W * 25)) dev (.sck(sck), .ss_n(ss_n), .mosi(mosi), .miso(miso),
    .rst_n(rst_n), .reply(reply), .got(got), .viol(viol));
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Counts edges from the take to the pin release, then from release to ready.
  task automatic xfer(input logic [1:0] op, input logic [7:0] b, input logic [2:0] w, input logic q,
                      output int lead, output int gap, output logic seen_rsp);
    seen_rsp = 1'b0;
    @(posedge clk);
    req_op <= op;
    req_byte <= b;
    req_wait <= w;
    quick <= q;
    reply <= b ^ 8'h5a;
    req_valid <= 1'b1;
    @(posedge clk);
    req_valid <= 1'b0;
    lead = 0;
    do begin
      @(posedge clk);
      #1;
      lead++;
      seen_rsp = seen_rsp | rsp_valid;
    end while (!(ss_n === 1'b1 && rst_n === 1'b1) && lead < 2000);
    gap = 0;
    while (req_ready !== 1'b1 && gap < 20000) begin
      @(posedge clk);
      #1;
      gap++;
    end
  endtask
  task automatic t_reset_values;
    check("sck idle", 1, sck);
    check("select idle", 1, ss_n);
    check("device reset idle", 1, rst_n);
    check("ready after reset", 1, req_ready);
    check("rsp byte after reset", 0, rsp_byte);
  endtask
  task automatic t_bytes(input logic q);
    int lead;
    int gap;
    logic r;
    logic [7:0] b;
    int full_w[8] = '{FULL_W, FULL_W, FULL_W, STORE_W, RESTORE_W, ERASE_W, FULL_W, FULL_W};
    int quick_w[8] = '{4000, 4000, 4000, STORE_W, 4000, 4000, FULL_W, 4000};
    for (int i = 0; i < (q ? 7 : 8); i++) begin
      b = 8'ha5 ^ 8'(i * 8'h13);
      xfer(tsh_pkg::OP_BYTE, b, 3'(i), q, lead, gap, r);
      check("byte length", BYTE_LEN, lead);
      check("response pulse", 1, r);
      check("byte from device", b ^ 8'h5a, rsp_byte);
      check("byte at device", b, got);
      check("gap", q ? quick_w[i] : full_w[i], gap);
    end
  endtask
  task automatic t_reset_op;
    int lead;
    int gap;
    logic r;
    xfer(tsh_pkg::OP_RESET, 8'h00, 3'h0, 1'b0, lead, gap, r);
    check("reset pulse", tsh_pkg::RST_LOW_CYC, lead);
    check("no response", 0, r);
    check("reset wait", RESET_W, gap);
  endtask
  task automatic t_wake_op;
    int lead;
    int gap;
    logic r;
    xfer(tsh_pkg::OP_WAKE, 8'h00, 3'h7, 1'b0, lead, gap, r);
    check("wake pulse", tsh_pkg::ENABLE_DLY_CYC, lead);
    check("no response", 0, r);
    check("wake wait", FULL_W, gap);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    t_reset_values();
    t_bytes(1'b0);
    t_bytes(1'b1);
    t_reset_op();
    t_wake_op();
    check("link timing faults", 0, viol);
    final_report();
  end
  // The full run needs about 35100 cycles; this leaves ample margin.
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    $display("[FAIL] run length expected done seen timeout");
    final_report();
  end
endmodule
